// ### inc/simlp_defs.svh
/*
 constants for the low-power, reset status and break block.
 assumes a 100 MHz system clock and the register access ports of simlp_top.
*/
`ifndef SIMLP_DEFS_SVH
`define SIMLP_DEFS_SVH

// reset source status bit positions
`define SIMLP_RS_LVI        0
`define SIMLP_RS_MODE       1
`define SIMLP_RS_BADADR     2
`define SIMLP_RS_BADOP      3
`define SIMLP_RS_WDOG       4
`define SIMLP_RS_PIN        5
`define SIMLP_RS_RSVD       6
`define SIMLP_RS_POR        7
`define SIMLP_RS_NONE       8'h00
`define SIMLP_RS_POR_ONLY   8'h80

// break flag control
`define SIMLP_BFC_CLR_EN    7
`define SIMLP_BFC_RESET     8'h00

// stop recovery in times-four clock cycles
`define SIMLP_REC_LONG      13'h1000
`define SIMLP_REC_SHORT     13'h0020
`define SIMLP_CNT_W         13
`define SIMLP_CNT_ZERO      13'h0000
`define SIMLP_CNT_ONE       13'h0001

`endif

// ### inc/simlp_pkg.sv
/*
 types for the low-power, reset status and break block.
 assumes simlp_defs.svh is available on the include path.
*/
package simlp_pkg;
	typedef enum logic [2:0] {
		SIMLP_RUN     = 3'b000,
		SIMLP_WAIT    = 3'b001,
		SIMLP_STOP    = 3'b011,
		SIMLP_RECOVER = 3'b010,
		SIMLP_STACK   = 3'b110
	} simlp_mode_t;
endpackage

// ### design/simlp_sticky.sv
/*
 one sticky status bit with clear-on-read, where a new set beats the clear.
 assumes set and read strobes on the same clock.
*/
`timescale 1ns/1ps
module simlp_sticky (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_srst,
	input  wire logic i_rst_val,
	// events
	input  wire logic i_set,
	input  wire logic i_clr,
	output logic      o_flag
);
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_flag <= i_rst_val ? 1'b1 : 1'b0;
		end else if (i_set) begin
			o_flag <= 1'b1;
		end else if (i_clr) begin
			o_flag <= 1'b0;
		end
	end
endmodule

// ### design/simlp_top.sv
/*
 low-power mode control, reset source status, break entry and flag protection.
 assumes the cpu core supplies instruction strobes and register access strobes on i_clk,
 and that the oscillator times-four enable comes back as a clock-enable-like tick.
*/
// How it works
// - flag registers two and three mirror pending requests: 1 pending, 0 none.
// - any reset source wins outright over all interrupts, with no arbitration.
// - a break request forces the cpu to the software interrupt vector.
// - during break, other modules may clear flags only if clear enable is 1.
// - a flag cleared during break stays cleared after break ends.
// - two-step clears stay blocked in break; second step afterwards clears normally.
// - wait or stop clears the global interrupt mask bit.
// - wait stops cpu clocks while peripheral clocks keep running.
// - interrupt wake from wait starts stacking two cycles later.
// - break during wait sets the break-during-lowpower flag.
// - watchdog stays enabled in wait when watchdog disable is 0.
// - wait also exits on any reset, or on break in emulation mode.
// - stop clears the counter, gates the times-two clock and, unless oscillator run in stop is set, times-four; interrupt, reset, break exit.
// - stacking after stop begins only once recovery has fully elapsed.
// - with oscillator run in stop set, times-four clock keeps running.
// - recovery is 4096 times-four cycles, or 32 with short recovery set.
// - counter held cleared from stop until recovery, then times the recovery.
// - reading the reset status register clears all its flags except any whose source sets it in the same cycle.
// - power-on sets its flag alone; other sources set only their own.
// - separate flags for pin, watchdog, bad opcode, bad fetch address, low voltage.
// - monitor entry reset flag records the monitor entry reset.
`timescale 1ns/1ps
`include "simlp_defs.svh"
module simlp_top
	import simlp_pkg::*;
#(
	parameter int unsigned REC_LONG  = `SIMLP_REC_LONG,
	parameter int unsigned REC_SHORT = `SIMLP_REC_SHORT
) (
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_srst,
	// reset sources, one-cycle pulses
	input  wire logic       i_por_evt,
	input  wire logic       i_pin_rst_evt,
	input  wire logic       i_wdog_rst_evt,
	input  wire logic       i_bad_op_evt,
	input  wire logic       i_bad_adr_evt,
	input  wire logic       i_mon_entry_evt,
	input  wire logic       i_lowv_rst_evt,
	// interrupt requests and cpu events
	input  wire logic [7:0] i_irq_mid,
	input  wire logic [7:0] i_irq_high,
	input  wire logic       i_irq_any,
	input  wire logic       i_break_req,
	input  wire logic       i_emul_mode,
	input  wire logic       i_wait_exec,
	input  wire logic       i_stop_exec,
	input  wire logic       i_break_exit,
	input  wire logic       i_x4_tick,
	// configuration
	input  wire logic       i_short_stop_recovery,
	input  wire logic       i_osc_run_in_stop,
	input  wire logic       i_watchdog_disable,
	// register access
	input  wire logic       i_rd_reset_status,
	input  wire logic       i_wr_break_ctl,
	input  wire logic [7:0] i_wdata,
	// peripheral flag clear requests
	input  wire logic       i_flag_clr_req,
	// register read data
	output logic [7:0]      o_interrupt_flags_two,
	output logic [7:0]      o_interrupt_flags_three,
	output logic [7:0]      o_reset_source_status,
	output logic [7:0]      o_break_flag_control,
	// cpu and clock control
	output logic            o_reset_active,
	output logic            o_force_swi,
	output logic            o_clear_imask,
	output logic            o_cpu_clk_en,
	output logic            o_periph_clk_en,
	output logic            o_x2_clk_en,
	output logic            o_x4_clk_en,
	output logic            o_watchdog_run,
	output logic            o_start_stacking,
	output logic            o_break_state,
	output logic            o_flag_clr_allow,
	output logic            o_break_during_lowpower_flag
);
	simlp_mode_t mode_q;
	logic [`SIMLP_CNT_W-1:0] cnt_q;
	logic [`SIMLP_CNT_W-1:0] rec_target;
	logic [7:0] rs_set;
	logic [7:0] rs_flags;
	logic       any_reset;
	logic       brk_clr_en;

	assign brk_clr_en = o_break_flag_control[`SIMLP_BFC_CLR_EN];
	assign any_reset  = i_por_evt | i_pin_rst_evt | i_wdog_rst_evt | i_bad_op_evt
		| i_bad_adr_evt | i_mon_entry_evt | i_lowv_rst_evt;
	assign rec_target = i_short_stop_recovery ? `SIMLP_CNT_W'(REC_SHORT)
		: `SIMLP_CNT_W'(REC_LONG);

	// reset source flags
	always_comb begin
		rs_set                     = `SIMLP_RS_NONE;
		rs_set[`SIMLP_RS_POR]      = i_por_evt;
		rs_set[`SIMLP_RS_PIN]      = i_pin_rst_evt;
		rs_set[`SIMLP_RS_WDOG]     = i_wdog_rst_evt;
		rs_set[`SIMLP_RS_BADOP]    = i_bad_op_evt;
		rs_set[`SIMLP_RS_BADADR]   = i_bad_adr_evt;
		rs_set[`SIMLP_RS_MODE]     = i_mon_entry_evt;
		rs_set[`SIMLP_RS_LVI]      = i_lowv_rst_evt;
	end

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_rs
			if (g == `SIMLP_RS_RSVD) begin : g_res
				assign rs_flags[g] = 1'b0;
			end else begin : g_bit
				simlp_sticky u_bit (
					.i_clk     (i_clk),
					.i_srst    (i_srst),
					.i_rst_val (g == `SIMLP_RS_POR),
					.i_set     (rs_set[g]),
					// power-on wipes the others
					.i_clr     (i_rd_reset_status | (i_por_evt & (g != `SIMLP_RS_POR))),
					.o_flag    (rs_flags[g])
				);
			end
		end
	endgenerate

	always_ff @(posedge i_clk) begin
		o_reset_source_status <= rs_flags;
	end

	// interrupt status mirrors
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_interrupt_flags_two <= 8'h00;
		end else begin
			o_interrupt_flags_two <= i_irq_mid;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_interrupt_flags_three <= 8'h00;
		end else begin
			o_interrupt_flags_three <= i_irq_high;
		end
	end

	// break flag control register
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_break_flag_control <= `SIMLP_BFC_RESET;
		end else if (i_wr_break_ctl) begin
			o_break_flag_control <= i_wdata & (8'h01 << `SIMLP_BFC_CLR_EN);
		end
	end

	// break state and flag protection
	always_ff @(posedge i_clk) begin
		if (i_srst || any_reset) begin
			o_break_state <= 1'b0;
		end else if (i_break_req) begin
			o_break_state <= 1'b1;
		end else if (i_break_exit) begin
			o_break_state <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_flag_clr_allow <= 1'b1;
		end else begin
			// peripherals gate both steps of any clear with this
			o_flag_clr_allow <= ~(o_break_state | i_break_req) | brk_clr_en;
		end
	end
	// a clear granted in break is a real clear and is never undone

	always_ff @(posedge i_clk) begin
		if (i_srst || any_reset) begin
			o_force_swi <= 1'b0;
		end else begin
			o_force_swi <= i_break_req & ~o_break_state;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_break_during_lowpower_flag <= 1'b0;
		end else if (i_break_req && (mode_q == SIMLP_WAIT || mode_q == SIMLP_STOP)) begin
			o_break_during_lowpower_flag <= 1'b1;
		end else if (i_break_exit && !o_break_state) begin
			o_break_during_lowpower_flag <= 1'b0;
		end
	end

	// low-power mode sequencer
	always_ff @(posedge i_clk) begin
		if (i_srst || any_reset) begin
			mode_q <= SIMLP_RUN;
		end else begin
			unique case (mode_q)
				SIMLP_RUN: begin
					if (i_stop_exec) begin
						mode_q <= SIMLP_STOP;
					end else if (i_wait_exec) begin
						mode_q <= SIMLP_WAIT;
					end
				end
				SIMLP_WAIT: begin
					if (i_break_req && i_emul_mode) begin
						mode_q <= SIMLP_RUN;
					end else if (i_irq_any) begin
						mode_q <= SIMLP_STACK;
					end
				end
				SIMLP_STOP: begin
					if (i_irq_any || i_break_req) begin
						mode_q <= SIMLP_RECOVER;
					end
				end
				SIMLP_RECOVER: begin
					if (i_x4_tick && (cnt_q + `SIMLP_CNT_ONE) >= rec_target) begin
						mode_q <= SIMLP_STACK;
					end
				end
				SIMLP_STACK: begin
					mode_q <= SIMLP_RUN;
				end
				default: begin
					mode_q <= SIMLP_RUN;
				end
			endcase
		end
	end

	// recovery counter
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			cnt_q <= `SIMLP_CNT_ZERO;
		end else if (mode_q == SIMLP_STOP || i_stop_exec) begin
			cnt_q <= `SIMLP_CNT_ZERO;
		end else if (i_x4_tick) begin
			cnt_q <= cnt_q + `SIMLP_CNT_ONE;
		end
	end

	// clock gating
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_cpu_clk_en <= 1'b1;
		end else begin
			o_cpu_clk_en <= (mode_q == SIMLP_RUN) || (mode_q == SIMLP_STACK);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_periph_clk_en <= 1'b1;
		end else begin
			o_periph_clk_en <= (mode_q != SIMLP_STOP) && (mode_q != SIMLP_RECOVER);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_x2_clk_en <= 1'b1;
		end else begin
			o_x2_clk_en <= (mode_q != SIMLP_STOP);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_x4_clk_en <= 1'b1;
		end else begin
			o_x4_clk_en <= (mode_q != SIMLP_STOP) || i_osc_run_in_stop;
		end
	end

	// cpu controls
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_clear_imask <= 1'b0;
		end else begin
			o_clear_imask <= (i_wait_exec | i_stop_exec) & (mode_q == SIMLP_RUN);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_start_stacking <= 1'b0;
		end else begin
			o_start_stacking <= (mode_q == SIMLP_STACK);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_reset_active <= 1'b0;
		end else begin
			o_reset_active <= any_reset;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_watchdog_run <= 1'b0;
		end else begin
			o_watchdog_run <= ~i_watchdog_disable & (mode_q != SIMLP_STOP);
		end
	end
endmodule

// ### dv/simlp_monitor.sv
/* port assertions for simlp_top.
 bound into simlp_top, single clock. */
`timescale 1ns/1ps
module simlp_monitor (
	input wire logic       i_clk,
	input wire logic       i_srst,
	input wire logic       i_por_evt,
	input wire logic       i_pin_rst_evt,
	input wire logic       i_wdog_rst_evt,
	input wire logic       i_bad_op_evt,
	input wire logic       i_bad_adr_evt,
	input wire logic       i_mon_entry_evt,
	input wire logic       i_lowv_rst_evt,
	input wire logic       i_irq_any,
	input wire logic       i_break_req,
	input wire logic       i_wait_exec,
	input wire logic       i_stop_exec,
	input wire logic       i_osc_run_in_stop,
	input wire logic       i_rd_reset_status,
	input wire logic [7:0] o_reset_source_status,
	input wire logic       o_force_swi,
	input wire logic       o_clear_imask,
	input wire logic       o_cpu_clk_en,
	input wire logic       o_periph_clk_en,
	input wire logic       o_x2_clk_en,
	input wire logic       o_x4_clk_en,
	input wire logic       o_start_stacking
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);
	wire ev_other = i_pin_rst_evt | i_wdog_rst_evt | i_bad_op_evt | i_bad_adr_evt | i_mon_entry_evt
		| i_lowv_rst_evt;
	wire ev = i_por_evt | ev_other;
	sequence s_wait_in; i_wait_exec ##1 !i_irq_any; endsequence
	sequence s_stop_in; i_stop_exec ##1 !i_irq_any; endsequence
	sequence s_wait_irq; !o_cpu_clk_en && o_x2_clk_en && $rose(i_irq_any); endsequence
	a_lowpower_unmask: assert property ((i_wait_exec || i_stop_exec) |=> o_clear_imask)
		else $error("mask not cleared");
	a_wait_gates: assert property (s_wait_in |=> !o_cpu_clk_en && o_periph_clk_en)
		else $error("wait clocks wrong");
	a_wait_wake: assert property (s_wait_irq |-> ##2 o_start_stacking)
		else $error("wait wake late");
	a_stop_osc: assert property (s_stop_in |=> !o_x2_clk_en && o_x4_clk_en == i_osc_run_in_stop)
		else $error("stop clocks wrong");
	a_read_clears: assert property (i_rd_reset_status && !ev ##1 !ev |=> o_reset_source_status == 8'h00)
		else $error("status not cleared");
	a_por_alone: assert property (i_por_evt && !ev_other ##1 !ev |=> o_reset_source_status == 8'h80)
		else $error("power-on flags wrong");
	a_pin_flag: assert property (i_pin_rst_evt |-> ##2 o_reset_source_status[5])
		else $error("pin flag missing");
	a_wdog_keeps: assert property (i_wdog_rst_evt && i_rd_reset_status |-> ##2 o_reset_source_status[4])
		else $error("watchdog flag lost");
	a_break_swi: assert property (o_cpu_clk_en && $rose(i_break_req) |=> o_force_swi)
		else $error("no swi force");
endmodule
bind simlp_top simlp_monitor u_mon (.i_clk, .i_srst, .i_por_evt, .i_pin_rst_evt, .i_wdog_rst_evt, .i_bad_op_evt,
	.i_bad_adr_evt, .i_mon_entry_evt, .i_lowv_rst_evt, .i_irq_any,
	.i_break_req, .i_wait_exec, .i_stop_exec, .i_osc_run_in_stop, .i_rd_reset_status, .o_reset_source_status,
	.o_force_swi, .o_clear_imask, .o_cpu_clk_en, .o_periph_clk_en, .o_x2_clk_en, .o_x4_clk_en, .o_start_stacking);

// ### dv/simlp_osc_model.sv
/* oscillator model: x4 tick every second cycle.
 runs free on the bench clock. */
`timescale 1ns/1ps
module simlp_osc_model (
	input  wire logic i_clk,
	input  wire logic i_srst,
	output logic      o_x4_tick
);
	always_ff @(posedge i_clk) begin
		o_x4_tick <= i_srst ? 1'b0 : !o_x4_tick;
	end
endmodule

// ### dv/simlp_tb.sv
/* bench for simlp_top.
 osc model gives the x4 tick; monitor is bound in. */
`timescale 1ns/1ps
module simlp_tb;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        emu = 1'b0;
	logic        osc = 1'b0;
	logic        wdd = 1'b0;
	logic [13:0] s = '0;
	logic [7:0]  mid = '0;
	logic [7:0]  wd = '0;
	wire         tick, software_interrupt, cpu, per, x2, x4, wdr, stk, alw, bsw, rst_act, bst;
	wire  [7:0]  f2, f3, rss, bfc;
	int          errors = 0;
	int          n_compared = 0;
	int          t;
	int          n;
	always #5 clk = ~clk;
	simlp_osc_model u_osc (.i_clk(clk), .i_srst(srst), .o_x4_tick(tick));
	simlp_top dut (.i_clk(clk), .i_srst(srst),
		.i_por_evt(s[0]), .i_pin_rst_evt(s[1]), .i_wdog_rst_evt(s[2]), .i_bad_op_evt(s[3]),
		.i_bad_adr_evt(s[4]), .i_mon_entry_evt(s[5]), .i_lowv_rst_evt(s[6]), .i_irq_mid(mid),
		.i_irq_high(~mid), .i_irq_any(s[13]), .i_break_req(s[9]), .i_emul_mode(emu),
		.i_wait_exec(s[7]), .i_stop_exec(s[8]), .i_break_exit(s[10]), .i_x4_tick(tick),
		.i_short_stop_recovery(osc), .i_osc_run_in_stop(osc), .i_watchdog_disable(wdd),
		.i_rd_reset_status(s[11]), .i_wr_break_ctl(s[12]), .i_wdata(wd), .i_flag_clr_req(1'b0),
		.o_interrupt_flags_two(f2), .o_interrupt_flags_three(f3), .o_reset_source_status(rss),
		.o_break_flag_control(bfc), .o_reset_active(rst_act), .o_force_swi(software_interrupt), .o_clear_imask(),
		.o_cpu_clk_en(cpu), .o_periph_clk_en(per), .o_x2_clk_en(x2), .o_x4_clk_en(x4),
		.o_watchdog_run(wdr), .o_start_stacking(stk), .o_break_state(bst), .o_flag_clr_allow(alw),
		.o_break_during_lowpower_flag(bsw));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic pl(input logic [13:0] v);
		@(posedge clk) s <= v;
		@(posedge clk) s <= '0;
	endtask
	task automatic rd_rss(input logic [7:0] exp);
		cyc(2);
		@(posedge clk) s <= 14'h0800;
		#1 chk(rss, exp);
		@(posedge clk) s <= '0;
	endtask
	task end_sim;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#200000;
		errors++;
		end_sim;
	end
	initial begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		rd_rss(8'h80);
		rd_rss(8'h00);
		chk(bfc, 8'h00);
		for (int k = 1; k < 7; k++) pl(14'h0001 << k);
		rd_rss(8'h3F);
		pl(14'h0002);
		#1 chk(rst_act, 8'h01);
		pl(14'h0001);
		rd_rss(8'h80);
		pl(14'h0804);
		rd_rss(8'h10);
		@(posedge clk) mid <= 8'hA5;
		cyc(2);
		chk(f2, 8'hA5);
		chk(f3, 8'h5A);
		pl(14'h0200);
		#1 chk(software_interrupt, 8'h01);
		chk(bst, 8'h01);
		cyc(2);
		chk(alw, 8'h00);
		pl(14'h0400);
		cyc(1);
		chk(bst, 8'h00);
		chk(alw, 8'h01);
		@(posedge clk) wd <= 8'hFF;
		pl(14'h1000);
		pl(14'h0200);
		cyc(2);
		chk(bfc, 8'h80);
		chk(alw, 8'h01);
		@(posedge clk) srst <= 1'b1;
		@(posedge clk) srst <= 1'b0;
		pl(14'h0080);
		cyc(1);
		chk(cpu, 8'h00);
		chk(per, 8'h01);
		chk(wdr, 8'h01);
		pl(14'h2000);
		cyc(1);
		chk(stk, 8'h01);
		chk(cpu, 8'h01);
		@(posedge clk) emu <= 1'b1;
		pl(14'h0080);
		pl(14'h0200);
		cyc(3);
		chk(bsw, 8'h01);
		chk(cpu, 8'h01);
		pl(14'h0080);
		pl(14'h0040);
		cyc(1);
		chk(cpu, 8'h01);
		@(posedge clk) wdd <= 1'b1;
		cyc(2);
		chk(wdr, 8'h00);
		@(posedge clk) srst <= 1'b1;
		@(posedge clk) srst <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			@(posedge clk) osc <= !i[0];
			pl(14'h0100);
			cyc(2);
			chk(x2, 8'h00);
			chk(x4, {7'h00, osc});
			pl(14'h2000);
			t = 0;
			n = 0;
			while (stk !== 1'b1 && n < 10000) begin
				@(posedge clk);
				#1 t += tick;
				n++;
			end
			chk({7'h00, t >= (i ? 4094 : 30) && t <= (i ? 4098 : 34)}, 8'h01);
		end
		end_sim;
	end
endmodule
